// File: csr_select.sv
// chip-select match, interrupt-acknowledge response and reset configuration
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - iack match only for externally driven cycles
// - internal interrupt source keeps select inactive
// - no vector: autovector ends the cycle
// - pin field low one, high strapped
// - general selects reset to fixed defaults
// - general selects quiet until written
// - boot pin field high one, both bytes
// - boot width strapped from data zero
// - boot base zero with 1 Mbyte block
// - boot option resets to thirteen waits
// - level and autovector ignored outside cpu space
// - iack cycle: fc 7, type f, ones
// - level equality, zero matches any
module csr_select
    import csr_pkg::*;
#(
    parameter int NSEL = 11  // general chip-selects
) (
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              nrst_i,
    // reset straps from data lines (pins)
    input  wire logic [7:0]        data_strap_i,
    // configuration writes
    input  wire logic              cfg_we_i,
    input  wire logic [3:0]        cfg_sel_i,        // NSEL = boot select
    input  wire logic [15:0]       cfg_base_i,
    input  wire logic [15:0]       cfg_opt_i,
    input  wire logic [1:0]        cfg_pin_i,
    // bus cycle in progress
    input  wire logic              cyc_i,            // address strobe phase
    input  wire logic              cyc_ext_i,        // cycle driven on external bus
    input  wire logic [23:0]       addr_i,
    input  wire logic [2:0]        function_code_i,
    input  wire logic              rd_i,
    input  wire logic              addr0_i,
    input  wire logic [1:0]        siz_i,
    // outputs
    output logic [NSEL-1:0]        sel_o,
    output logic                   boot_select_out_o,
    output logic                   autovector_request_o,
    output logic                   transfer_acknowledge_o,
    output logic [3:0]             wait_count_o,
    output logic                   boot_wide_o,
    output logic [2*NSEL-1:0]      pin_assign_o
);
    // the select index port is four bits and the strap map covers eleven selects,
    // so anything outside 1..11 cannot be served and is refused at elaboration
    generate
        if (NSEL < 1 || NSEL > 11) begin : g_bad_nsel
            $error("NSEL out of range");
        end
    endgenerate

    // one chip-select's setting
    typedef struct packed {
        logic [15:0] base;   // [15:3] address, [2:0] block size
        logic [15:0] opt;
        logic [1:0]  pin;
    } csr_cs_s;

    typedef struct packed {
        csr_cs_s [NSEL:0] cs;     // entry NSEL is the boot select
        logic [6:0]       strap1; // first stage of straps 7..1
        logic [6:0]       strap2;
        logic             in_rst;
        logic             wide;
        logic [NSEL:0]    hit;
        logic             autovector_request;
        logic             ack;
        logic [3:0]       waits;
    } csr_state_s;

    csr_state_s st_reg;
    csr_state_s st_next;
    logic       strap0_s1;  // boot width strap, stage one
    logic       strap0_s2;

    // two-flop synchroniser for the boot width strap
    always_ff @(posedge clk_sys_i) begin
        strap0_s1 <= data_strap_i[0];
        strap0_s2 <= strap0_s1;
    end

    // address lines compared for a block size code
    function automatic logic [12:0] blk_mask(input logic [2:0] bs);
        logic [12:0] m;
        m = 13'h1fff;
        case (bs)
            3'h0: m = 13'h1fff;
            3'h1: m = 13'h1ffc;
            3'h2: m = 13'h1ff8;
            3'h3: m = 13'h1fe0;
            3'h4: m = 13'h1fc0;
            3'h5: m = 13'h1f80;
            3'h6: m = 13'h1f00;
            default: m = 13'h1e00;
        endcase
        return m;
    endfunction

    logic          iack_cyc;   // cpu space interrupt acknowledge
    logic [NSEL:0] match;

    // iack cycle recognition
    always_comb begin
        iack_cyc = (function_code_i == FC_CPU) && (addr_i[19:16] == CYC_IACK);
    end

    // per-select match logic
    genvar g;
    generate
        for (g = 0; g <= NSEL; g++) begin : g_match
            logic [15:0] o;
            logic        sp_ok, lvl_ok, rw_ok, by_ok, ad_ok, wide_port;
            always_comb begin
                o = st_reg.cs[g].opt;
                wide_port = (g == NSEL) ? st_reg.wide : 1'b1;
                ad_ok = ((addr_i[23:11] ^ st_reg.cs[g].base[15:3])
                        & blk_mask(st_reg.cs[g].base[2:0])) == 13'h0000;
                case (o[OPT_SPACE +: 2])
                    SPACE_CPU:  sp_ok = function_code_i == FC_CPU;
                    SPACE_USER: sp_ok = function_code_i[2] == 1'b0;
                    SPACE_SUP:  sp_ok = function_code_i[2] == 1'b1 && function_code_i != FC_CPU;
                    default:    sp_ok = function_code_i != FC_CPU;
                endcase
                // level compared only in cpu space
                lvl_ok = (o[OPT_SPACE +: 2] != SPACE_CPU) || !iack_cyc
                       || (o[OPT_LVL +: 3] == LVL_ANY) || (o[OPT_LVL +: 3] == addr_i[3:1]);
                case (o[OPT_RW +: 2])
                    RW_READ:  rw_ok = rd_i;
                    RW_WRITE: rw_ok = !rd_i;
                    RW_BOTH:  rw_ok = 1'b1;
                    default:  rw_ok = 1'b0;
                endcase
                // disabled lanes keep the select off
                case (o[OPT_BYTE +: 2])
                    BYTE_OFF:   by_ok = 1'b0;
                    BYTE_UPPER: by_ok = !wide_port || !addr0_i;
                    BYTE_LOWER: by_ok = !wide_port || addr0_i || siz_i != 2'h1;
                    default:    by_ok = 1'b1;
                endcase
                // iack cycles only match once on the external bus
                match[g] = cyc_i && ad_ok && sp_ok && lvl_ok && rw_ok && by_ok
                         && st_reg.cs[g].pin[1] && (!iack_cyc || cyc_ext_i);
            end
            // a general select with its lanes off never answers
            if (g < NSEL) begin : g_chk
                a_lane_quiet: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
                    (st_reg.cs[g].opt[OPT_BYTE +: 2] == BYTE_OFF) |=> !st_reg.hit[g])
                    else $error("select with lanes off answered");
            end
            // a select outside cpu space never takes a cpu space cycle
            a_space_gate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
                (cyc_i && st_reg.cs[g].opt[OPT_SPACE +: 2] != SPACE_CPU && function_code_i == FC_CPU)
                |=> !st_reg.hit[g])
                else $error("non cpu select took cpu cycle");
            // a cpu space select with a set level ignores other levels
            a_level_miss: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
                (cyc_i && iack_cyc && st_reg.cs[g].opt[OPT_SPACE +: 2] == SPACE_CPU
                 && st_reg.cs[g].opt[OPT_LVL +: 3] != LVL_ANY
                 && st_reg.cs[g].opt[OPT_LVL +: 3] != addr_i[3:1]) |=> !st_reg.hit[g])
                else $error("select took wrong iack level");
        end
    endgenerate

    // next-state logic
    always_comb begin
        st_next = st_reg;
        st_next.strap1 = data_strap_i[7:1];
        st_next.strap2 = st_reg.strap1;
        st_next.in_rst = 1'b0;
        // straps taken at the first edge after release
        if (st_reg.in_rst) begin
            for (int i = 0; i < NSEL; i++) begin
                st_next.cs[i].pin = {st_reg.strap2[i % 7], 1'b1};
            end
            st_next.wide = strap0_s2;
        end
        // a write in the release cycle lands after the strap load and so wins
        // indexes above NSEL are dropped, there is no select behind them
        if (cfg_we_i && cfg_sel_i <= 4'(NSEL)) begin
            st_next.cs[cfg_sel_i].base = cfg_base_i;
            st_next.cs[cfg_sel_i].opt  = cfg_opt_i;
            st_next.cs[cfg_sel_i].pin  = cfg_pin_i;
        end
        st_next.hit = match;
        st_next.autovector_request = 1'b0;
        st_next.ack = 1'b0;
        st_next.waits = WAIT_NONE;
        for (int i = 0; i <= NSEL; i++) begin
            if (match[i]) begin
                // autovector only for cpu space selects
                if (iack_cyc && st_reg.cs[i].opt[OPT_SPACE +: 2] == SPACE_CPU
                    && st_reg.cs[i].opt[OPT_AUTOVECTOR_REQUEST]) begin
                    st_next.autovector_request = 1'b1;
                end else begin
                    st_next.ack = 1'b1;
                    st_next.waits = st_reg.cs[i].opt[OPT_WAIT +: 4];
                end
            end
        end
    end

    // state register with reset defaults
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            st_reg <= '0;
            for (int i = 0; i < NSEL; i++) begin
                st_reg.cs[i].base <= {BASE_RST, BLK_2K};
                st_reg.cs[i].opt  <= OPT_GEN_RST;
                st_reg.cs[i].pin  <= PIN_LOW_RST;
            end
            st_reg.cs[NSEL].base <= {BASE_RST, BLK_1M};
            st_reg.cs[NSEL].opt  <= OPT_BOOT_RST;
            st_reg.cs[NSEL].pin  <= BOOT_PIN_RST;
            st_reg.in_rst <= 1'b1;
            st_reg.wide <= 1'b1;
            // the strap synchroniser keeps running in reset so the levels are settled at release
            st_reg.strap1 <= data_strap_i[7:1];
            st_reg.strap2 <= st_reg.strap1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs from registers
    always_comb begin
        sel_o = st_reg.hit[NSEL-1:0];
        boot_select_out_o = st_reg.hit[NSEL];
        autovector_request_o = st_reg.autovector_request;
        transfer_acknowledge_o = st_reg.ack;
        wait_count_o = st_reg.waits;
        boot_wide_o = st_reg.wide;
        for (int i = 0; i < NSEL; i++) begin
            pin_assign_o[2*i +: 2] = st_reg.cs[i].pin;
        end
    end

    // boot select still holding its reset settings
    logic boot_at_rst;
    always_comb begin
        boot_at_rst = (st_reg.cs[NSEL].base == {BASE_RST, BLK_1M})
                    && (st_reg.cs[NSEL].opt == OPT_BOOT_RST) && st_reg.cs[NSEL].pin[1];
    end

    // supervisor program fetch of the reset vector
    sequence s_vec_fetch;
        cyc_i && addr_i == 24'h000000 && rd_i && function_code_i == 3'h6;
    endsequence

    // an iack that stays inside the chip
    sequence s_int_iack;
        cyc_i && iack_cyc && !cyc_ext_i;
    endsequence

    // checks
    a_iack_internal: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        (iack_cyc && !cyc_ext_i) |=> (st_reg.hit == '0))
        else $error("select answered internal iack");
    a_boot_match: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        boot_at_rst ##0 s_vec_fetch |=> boot_select_out_o)
        else $error("boot select missed reset fetch");
    a_boot_wait_out: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        boot_at_rst ##0 s_vec_fetch |=> wait_count_o == WAIT_BOOT)
        else $error("boot fetch wait count wrong");
    a_gen_quiet: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        $rose(nrst_i) ##0 !cfg_we_i [*3] |-> sel_o == '0)
        else $error("general select before config");
    a_pin_low: assert property (@(posedge clk_sys_i)
        $past(st_reg.in_rst) && !$past(cfg_we_i) |-> pin_assign_o[0])
        else $error("pin field low bit not one");
    a_boot_pin: assert property (@(posedge clk_sys_i)
        !nrst_i |=> st_reg.cs[NSEL].pin == 2'h2 && st_reg.cs[NSEL].opt[OPT_BYTE +: 2] == BYTE_BOTH)
        else $error("boot pin field reset wrong");
    a_width_hold: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        !st_reg.in_rst |=> $stable(boot_wide_o))
        else $error("boot width changed");
    a_gen_reset: assert property (@(posedge clk_sys_i)
        !nrst_i |=> st_reg.cs[0].base == 16'h0000 && st_reg.cs[0].opt == 16'h0000)
        else $error("general reset wrong");
    a_boot_waits: assert property (@(posedge clk_sys_i)
        !nrst_i |=> st_reg.cs[NSEL].opt[OPT_WAIT +: 4] == 4'hd)
        else $error("boot waits wrong");
    a_autovector_request_cpu: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        autovector_request_o |-> $past(iack_cyc))
        else $error("autovector outside iack");
    // neither answer line moves for an iack that never left the chip
    a_iack_ext_only: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        s_int_iack |=> !autovector_request_o && !transfer_acknowledge_o)
        else $error("answer to internal iack");
    // straps land in the register on the edge that leaves reset
    a_strap_load: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        st_reg.in_rst |=> boot_wide_o == $past(strap0_s2))
        else $error("boot width not taken from strap");
    a_pin_high: assert property (@(posedge clk_sys_i) disable iff (!nrst_i)
        st_reg.in_rst && !cfg_we_i |=> pin_assign_o[1] == $past(st_reg.strap2[0]))
        else $error("pin field high bit not strapped");
endmodule

`default_nettype wire

// File: csr_pkg.sv
// package: constants for the chip-select interrupt-acknowledge and reset block
package csr_pkg;
    // block size codes
    localparam logic [2:0] BLK_2K      = 3'h0;
    localparam logic [2:0] BLK_64K     = 3'h3;
    localparam logic [2:0] BLK_1M      = 3'h7;
    // byte lane field codes
    localparam logic [1:0] BYTE_OFF    = 2'h0;
    localparam logic [1:0] BYTE_LOWER  = 2'h1;
    localparam logic [1:0] BYTE_UPPER  = 2'h2;
    localparam logic [1:0] BYTE_BOTH   = 2'h3;
    // read/write field codes
    localparam logic [1:0] RW_OFF      = 2'h0;
    localparam logic [1:0] RW_READ     = 2'h1;
    localparam logic [1:0] RW_WRITE    = 2'h2;
    localparam logic [1:0] RW_BOTH     = 2'h3;
    // address space codes
    localparam logic [1:0] SPACE_CPU   = 2'h0;
    localparam logic [1:0] SPACE_USER  = 2'h1;
    localparam logic [1:0] SPACE_SUP   = 2'h2;
    localparam logic [1:0] SPACE_SU    = 2'h3;
    // cycle encodings
    localparam logic [2:0] FC_CPU      = 3'h7;
    localparam logic [3:0] CYC_IACK    = 4'hf;
    localparam logic [2:0] LVL_ANY     = 3'h0;
    // wait-state counts
    localparam logic [3:0] WAIT_NONE   = 4'h0;
    localparam logic [3:0] WAIT_BOOT   = 4'hd;
    // reset values
    localparam logic [12:0] BASE_RST   = 13'h0000;
    localparam logic [1:0]  PIN_LOW_RST = 2'h1;
    localparam logic [1:0]  BOOT_PIN_RST = 2'h2;
    // field positions of the option word
    localparam int OPT_MODE  = 15;
    localparam int OPT_BYTE  = 13;
    localparam int OPT_RW    = 11;
    localparam int OPT_STRB  = 10;
    localparam int OPT_WAIT  = 6;
    localparam int OPT_SPACE = 4;
    localparam int OPT_LVL   = 1;
    localparam int OPT_AUTOVECTOR_REQUEST  = 0;
    localparam logic [15:0] OPT_GEN_RST  = 16'h0000;
    localparam logic [15:0] OPT_BOOT_RST = 16'h7b70;
endpackage

// File: csr_strap_model.sv
// board-side model: drivers that hold the data lines during reset
`timescale 1ns/1ps
`default_nettype none
module csr_strap_model (
    // clock and reset seen by the board
    input  wire logic       clk_sys_i,
    input  wire logic       nrst_i,
    // level the strap driver puts on the lines while in reset
    input  wire logic [7:0] strap_val_i,
    // data lines as seen by the device
    output logic [7:0]      data_o
);
    logic [2:0] hold_reg;  // edges since release

    // keep driving a few edges past release so the strap sync sees a clean value
    always_ff @(posedge clk_sys_i) begin
        if (!nrst_i) begin
            hold_reg <= 3'h0;
        end else if (hold_reg != 3'h4) begin
            hold_reg <= hold_reg + 3'h1;
        end
    end

    // actively driven in reset, bus loading cannot flip it
    // once let go the weak pull-ups take every line high
    assign data_o = (!nrst_i || hold_reg != 3'h4) ? strap_val_i : 8'hff;
endmodule
`default_nettype wire

// File: chip_select_iack_and_reset_test.sv
// self-checking bench for the chip-select iack and reset block
`timescale 1ns/1ps
`default_nettype none
module chip_select_iack_and_reset_test
    import csr_pkg::*;
;
    typedef struct {
        logic [2:0] fc; logic [23:0] addr; logic ext, rd, a0; logic [1:0] siz;
        logic [10:0] sel; logic boot, autovector_request, ack; logic [3:0] wt;
    } csr_row_s;  // one bus cycle and the answer it should get

    logic        clk_sys_i = 1'b0;
    logic        nrst_i    = 1'b0;
    logic        cfg_we    = 1'b0;
    logic        cyc       = 1'b0;
    logic [3:0]  csel      = 4'h0;
    logic [15:0] cbase     = 16'h0000;
    logic [15:0] copt      = 16'h0000;
    logic [1:0]  cpin      = 2'h3;   // every select given chip-select function
    logic [7:0]  strap_val = 8'ha4;
    wire  logic [7:0] data_lines;
    csr_row_s    cur = '{3'h0, 24'h0, 1'b0, 1'b0, 1'b0, 2'h0, 11'h0, 1'b0, 1'b0, 1'b0, 4'h0};
    logic [10:0] sel;
    logic [21:0] pins;
    logic [3:0]  wcnt;
    logic        boot, autovector_request, ack, wide;
    int          err_total = 0;
    int          checked   = 0;

    // iack rows keep byte-lane lower, read only, base all ones
    csr_row_s rows [8] = '{
        '{3'h6,   24'h000000, 1, 1, 0, 2'h2, 11'h000, 1, 0, 1, WAIT_BOOT},
        '{3'h1,   24'h0ffffe, 1, 0, 0, 2'h2, 11'h000, 1, 0, 1, WAIT_BOOT},
        '{3'h6,   24'h100000, 1, 1, 0, 2'h2, 11'h000, 0, 0, 0, WAIT_NONE},
        '{FC_CPU, 24'hfffff7, 1, 1, 1, 2'h1, 11'h001, 0, 1, 0, WAIT_NONE},
        '{FC_CPU, 24'hfffffb, 1, 1, 1, 2'h1, 11'h000, 0, 0, 0, WAIT_NONE},
        '{FC_CPU, 24'hfffff7, 0, 1, 1, 2'h1, 11'h000, 0, 0, 0, WAIT_NONE},
        '{FC_CPU, 24'hfffff7, 1, 0, 1, 2'h1, 11'h000, 0, 0, 0, WAIT_NONE},
        '{3'h6,   24'h200004, 1, 1, 0, 2'h2, 11'h004, 0, 0, 1, WAIT_NONE}
    };

    // 20 MHz system clock
    always #25 clk_sys_i = ~clk_sys_i;

    csr_strap_model i_straps (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .strap_val_i(strap_val), .data_o(data_lines));

    csr_select #(.NSEL(11)) i_dut (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .data_strap_i(data_lines),
        .cfg_we_i(cfg_we), .cfg_sel_i(csel), .cfg_base_i(cbase), .cfg_opt_i(copt), .cfg_pin_i(cpin),
        .cyc_i(cyc), .cyc_ext_i(cur.ext), .addr_i(cur.addr), .function_code_i(cur.fc), .rd_i(cur.rd),
        .addr0_i(cur.a0), .siz_i(cur.siz), .sel_o(sel), .boot_select_out_o(boot),
        .autovector_request_o(autovector_request), .transfer_acknowledge_o(ack), .wait_count_o(wcnt),
        .boot_wide_o(wide), .pin_assign_o(pins));

    // pin fields: low bit one, high bit from the select's data line
    function automatic logic [21:0] pins_exp(input logic [7:0] s);
        pins_exp = 22'h0;
        for (int i = 0; i < 11; i++) begin
            pins_exp[2*i +: 2] = {s[i % 7 + 1], 1'b1};
        end
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // drive one cycle, let the registered answer land, look at it
    task automatic bus(input csr_row_s r);
        @(posedge clk_sys_i);
        cur <= r;
        cyc <= 1'b1;
        @(posedge clk_sys_i);
        cyc <= 1'b0;
        @(negedge clk_sys_i);
        chk(32'(sel), 32'(r.sel));
        chk(32'(boot), 32'(r.boot));
        chk(32'(autovector_request), 32'(r.autovector_request));
        chk(32'(ack), 32'(r.ack));
        // wait count only means something while a select answers
        if (r.boot || r.sel != 11'h0) begin
            chk(32'(wcnt), 32'(r.wt));
        end
    endtask

    task automatic cfg(input logic [3:0] s, input logic [15:0] b, input logic [15:0] o);
        @(posedge clk_sys_i);
        cfg_we <= 1'b1;
        csel   <= s;
        cbase  <= b;
        copt   <= o;
        @(posedge clk_sys_i);
        cfg_we <= 1'b0;
    endtask

    // reset for five edges, checking the in-reset values before release
    task automatic do_reset(input logic [7:0] s);
        @(posedge clk_sys_i);
        nrst_i    <= 1'b0;
        strap_val <= s;
        repeat (4) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk(32'(wide), 32'h1);
        chk(32'(pins), 32'h155555);
        @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
    endtask

    task automatic end_of_test;
        $display("counts: checked=%0d mismatches=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // watchdog: the whole run needs under a hundred cycles
    initial begin
        repeat (3000) @(posedge clk_sys_i);
        err_total++;
        end_of_test;
    end

    initial begin
        do_reset(8'ha4);
        repeat (6) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk(32'(wide), 32'h0);
        chk(32'(pins), 32'(pins_exp(8'ha4)));
        // cpu-space access at base zero: unwritten selects stay quiet
        bus('{FC_CPU, 24'h000000, 1, 1, 0, 2'h2, 11'h000, 0, 0, 0, WAIT_NONE});
        $display("test reset_defaults done");
        cfg(4'h0, 16'hfffb, 16'h2807);
        cfg(4'h2, 16'h2000, 16'h7839);
        foreach (rows[i]) begin
            bus(rows[i]);
        end
        $display("test table done");
        // select 0 lanes off, select 1 answers any level with two waits
        cfg(4'h0, 16'hfffb, 16'h0807);
        cfg(4'h1, 16'hfffb, 16'h2880);
        bus('{FC_CPU, 24'hfffffd, 1, 1, 1, 2'h1, 11'h002, 0, 0, 1, 4'h2});
        $display("test level_any done");
        // second reset in mid-run with new straps clears the settings
        do_reset(8'h01);
        @(negedge clk_sys_i);
        chk(32'(wide), 32'h1);
        chk(32'(pins), 32'(pins_exp(8'h01)));
        bus('{FC_CPU, 24'hfffffd, 1, 1, 1, 2'h1, 11'h000, 0, 0, 0, WAIT_NONE});
        bus(rows[0]);
        $display("test second_reset done");
        end_of_test;
    end
endmodule
`default_nettype wire
